/* File: pkg/prad_pkg.sv */
package prad_pkg;

  // ==========================================================
  // Geometry
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int PAGE_W = 3;
  localparam int NUM_REGS = 64;
  localparam int SYNC_W = 18;

  // ==========================================================
  // Page register layout and reset values
  localparam logic [2:0] PAGE_REG_OFS = 3'h0;
  localparam int PG_MODE_BIT = 7;
  localparam int PG_NUM_MSB = 2;
  localparam logic [7:0] PAGE_RST = 8'h80;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] CMD_IDLE = 8'h00;
  // Value returned for a write-only location; software must not rely on it
  localparam logic [7:0] WO_READ_VAL = 8'h00;

  // ==========================================================
  // Register offsets
  localparam logic [5:0] ADDR_CMD = 6'h01;
  localparam logic [5:0] ADDR_FIFO_DATA = 6'h02;
  localparam logic [5:0] ADDR_PRI_STATUS = 6'h03;
  localparam logic [5:0] ADDR_FIFO_LEN = 6'h04;
  localparam logic [5:0] ADDR_SEC_STATUS = 6'h05;
  localparam logic [5:0] ADDR_INT_EN = 6'h06;
  localparam logic [5:0] ADDR_INT_REQ = 6'h07;
  localparam logic [5:0] ADDR_CONTROL = 6'h09;
  localparam logic [5:0] ADDR_ERR_FLAG = 6'h0a;
  localparam logic [5:0] ADDR_COLL_POS = 6'h0b;
  localparam logic [5:0] ADDR_TIMER_VAL = 6'h0c;
  localparam logic [5:0] ADDR_CRC_LSB = 6'h0d;
  localparam logic [5:0] ADDR_CRC_MSB = 6'h0e;
  localparam logic [5:0] ADDR_WO_FIRST = 6'h3d;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {ACC_PAGE, ACC_RW, ACC_DYN, ACC_RO, ACC_WO} prad_acc_t;

  typedef struct packed {
    logic [7:0] pri_status;
    logic [7:0] fifo_len;
    logic [7:0] sec_status;
    logic [7:0] err_flag;
    logic [7:0] coll_pos;
    logic [7:0] timer_val;
    logic [7:0] crc_lsb;
    logic [7:0] crc_msb;
  } prad_status_t;

  typedef struct packed {
    logic valid;
    logic [5:0] addr;
    logic [7:0] data;
  } prad_dyn_wr_t;

  function automatic prad_acc_t acc_class(input logic [5:0] a);
    prad_acc_t c;
    c = ACC_RW;
    if (a[2:0] == PAGE_REG_OFS) begin
      c = ACC_PAGE;
    end else begin
      case (a)
        ADDR_CMD, ADDR_FIFO_DATA, ADDR_INT_REQ, ADDR_CONTROL: c = ACC_DYN;
        ADDR_PRI_STATUS, ADDR_FIFO_LEN, ADDR_SEC_STATUS, ADDR_ERR_FLAG,
        ADDR_COLL_POS, ADDR_TIMER_VAL, ADDR_CRC_LSB, ADDR_CRC_MSB: c = ACC_RO;
        default: c = (a >= ADDR_WO_FIRST) ? ACC_WO : ACC_RW;
      endcase
    end
    return c;
  endfunction

endpackage

/* File: src/prad_sync.sv */
`timescale 1ns/1ns
module prad_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  // ==========================================================
  // Two-stage synchroniser; only the second stage reads the first
  always_comb begin
    meta_next = i_d;
    q_next = meta_reg;
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_reg <= '0;
      q_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      q_reg <= q_next;
    end
  end

  assign o_q = q_reg;

endmodule // prad_sync

/* File: src/prad_addr_assemble.sv */
`timescale 1ns/1ns
module prad_addr_assemble (
  input wire logic i_bus_muxed,
  input wire logic i_paging_mode_enable,
  input wire logic [2:0] i_page_number_field,
  input wire logic [5:0] i_raw_addr,
  output logic [5:0] o_eff_addr
);

  // ==========================================================
  // Address assembly
  // Dedicated bus always pages; the muxed bus pages only when enabled
  always_comb begin
    if (!i_bus_muxed || i_paging_mode_enable) begin
      o_eff_addr = {i_page_number_field, i_raw_addr[2:0]};
    end else begin
      o_eff_addr = i_raw_addr;
    end
  end

endmodule // prad_addr_assemble

/* File: src/prad_regbank.sv */
`timescale 1ns/1ns
module prad_regbank (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_bus_muxed,
  input wire logic i_ale,
  input wire logic i_wr_strobe,
  input wire logic i_rd_strobe,
  input wire logic [5:0] i_addr_lines,
  input wire logic [7:0] i_wdata,
  input wire logic i_cmd_done,
  input wire prad_pkg::prad_dyn_wr_t i_dyn_wr,
  input wire prad_pkg::prad_status_t i_status,
  output logic [7:0] o_rd_data,
  output logic o_rd_valid,
  output logic o_cmd_start,
  output logic o_paging_mode_enable,
  output logic [2:0] o_page_number_field,
  output logic [511:0] o_reg_image
);

  // ==========================================================
  // Pin synchronisation
  logic [17:0] sync_in;
  logic [17:0] sync_out;
  logic muxed_s;
  logic ale_s;
  logic wr_s;
  logic rd_s;
  logic [5:0] addr_s;
  logic [7:0] wdata_s;

  assign sync_in = {i_bus_muxed, i_ale, i_wr_strobe, i_rd_strobe, i_addr_lines, i_wdata};

  prad_sync #(
    .W(prad_pkg::SYNC_W)
  ) u_sync (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_d(sync_in),
    .o_q(sync_out)
  );

  assign {muxed_s, ale_s, wr_s, rd_s, addr_s, wdata_s} = sync_out;

  // ==========================================================
  // Strobe edges and muxed address latch
  logic ale_prev_reg;
  logic ale_prev_next;
  logic wr_prev_reg;
  logic wr_prev_next;
  logic rd_prev_reg;
  logic rd_prev_next;
  logic [5:0] lat_addr_reg;
  logic [5:0] lat_addr_next;
  logic ale_go;
  logic wr_go;
  logic rd_go;

  assign ale_go = ale_s & ~ale_prev_reg;
  assign wr_go = wr_s & ~wr_prev_reg;
  assign rd_go = rd_s & ~rd_prev_reg;

  always_comb begin
    ale_prev_next = ale_s;
    wr_prev_next = wr_s;
    rd_prev_next = rd_s;
    lat_addr_next = lat_addr_reg;
    // All six lines are taken in the single address phase
    if (ale_go) begin
      lat_addr_next = addr_s;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ale_prev_reg <= 1'b0;
      wr_prev_reg <= 1'b0;
      rd_prev_reg <= 1'b0;
      lat_addr_reg <= 6'h00;
    end else begin
      ale_prev_reg <= ale_prev_next;
      wr_prev_reg <= wr_prev_next;
      rd_prev_reg <= rd_prev_next;
      lat_addr_reg <= lat_addr_next;
    end
  end

  // ==========================================================
  // Effective address
  logic [7:0] page_reg;
  logic [7:0] page_next;
  logic [5:0] raw_addr;
  logic [5:0] eff_addr;
  prad_pkg::prad_acc_t acc;

  assign raw_addr = muxed_s ? lat_addr_reg : addr_s;

  // Crossing pages on the dedicated bus relies on a prior page write
  prad_addr_assemble u_asm (
    .i_bus_muxed(muxed_s),
    .i_paging_mode_enable(page_reg[prad_pkg::PG_MODE_BIT]),
    .i_page_number_field(page_reg[prad_pkg::PG_NUM_MSB:0]),
    .i_raw_addr(raw_addr),
    .o_eff_addr(eff_addr)
  );

  // Offset zero of any page decodes to the single page register
  assign acc = prad_pkg::acc_class(eff_addr);

  // ==========================================================
  // Register storage
  logic [63:0][7:0] regs_reg;
  logic [63:0][7:0] regs_next;
  logic cmd_start_next;
  logic cmd_start_reg;

  always_comb begin
    regs_next = regs_reg;
    page_next = page_reg;
    cmd_start_next = 1'b0;
    if (wr_go) begin
      case (acc)
        // Stored bits are kept as written, expected-value bits included
        prad_pkg::ACC_PAGE: page_next = wdata_s;
        prad_pkg::ACC_RW: regs_next[eff_addr] = wdata_s;
        prad_pkg::ACC_DYN: regs_next[eff_addr] = wdata_s;
        prad_pkg::ACC_WO: regs_next[eff_addr] = wdata_s;
        prad_pkg::ACC_RO: regs_next = regs_reg;
        default: regs_next = regs_reg;
      endcase
      cmd_start_next = (eff_addr == prad_pkg::ADDR_CMD);
    end
    // Engine updates land after the processor write so hardware wins a tie
    if (i_dyn_wr.valid && prad_pkg::acc_class(i_dyn_wr.addr) == prad_pkg::ACC_DYN) begin
      regs_next[i_dyn_wr.addr] = i_dyn_wr.data;
    end
    if (i_cmd_done) begin
      regs_next[prad_pkg::ADDR_CMD] = prad_pkg::CMD_IDLE;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      regs_reg <= '0;
      page_reg <= prad_pkg::PAGE_RST;
      cmd_start_reg <= 1'b0;
    end else begin
      regs_reg <= regs_next;
      page_reg <= page_next;
      cmd_start_reg <= cmd_start_next;
    end
  end

  // ==========================================================
  // Read path
  logic [7:0] rd_data_reg;
  logic [7:0] rd_data_next;
  logic rd_valid_reg;
  logic rd_valid_next;
  logic [7:0] ro_byte;

  always_comb begin
    case (eff_addr)
      prad_pkg::ADDR_PRI_STATUS: ro_byte = i_status.pri_status;
      prad_pkg::ADDR_FIFO_LEN: ro_byte = i_status.fifo_len;
      prad_pkg::ADDR_SEC_STATUS: ro_byte = i_status.sec_status;
      prad_pkg::ADDR_ERR_FLAG: ro_byte = i_status.err_flag;
      prad_pkg::ADDR_COLL_POS: ro_byte = i_status.coll_pos;
      prad_pkg::ADDR_TIMER_VAL: ro_byte = i_status.timer_val;
      prad_pkg::ADDR_CRC_LSB: ro_byte = i_status.crc_lsb;
      prad_pkg::ADDR_CRC_MSB: ro_byte = i_status.crc_msb;
      default: ro_byte = prad_pkg::REG_RST;
    endcase
  end

  always_comb begin
    rd_data_next = rd_data_reg;
    rd_valid_next = 1'b0;
    if (rd_go) begin
      rd_valid_next = 1'b1;
      case (acc)
        prad_pkg::ACC_PAGE: rd_data_next = page_reg;
        prad_pkg::ACC_RW: rd_data_next = regs_reg[eff_addr];
        prad_pkg::ACC_DYN: rd_data_next = regs_reg[eff_addr];
        prad_pkg::ACC_RO: rd_data_next = ro_byte;
        prad_pkg::ACC_WO: rd_data_next = prad_pkg::WO_READ_VAL;
        default: rd_data_next = prad_pkg::REG_RST;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rd_data_reg <= 8'h00;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_data_reg <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
    end
  end

  // ==========================================================
  // Outputs
  assign o_rd_data = rd_data_reg;
  assign o_rd_valid = rd_valid_reg;
  assign o_cmd_start = cmd_start_reg;
  assign o_paging_mode_enable = page_reg[prad_pkg::PG_MODE_BIT];
  assign o_page_number_field = page_reg[prad_pkg::PG_NUM_MSB:0];
  assign o_reg_image = regs_reg;

  // ==========================================================
  // Assertions
  property p_page_alias;
    @(posedge i_clk) disable iff (!i_resetn)
    wr_go && eff_addr[2:0] == 3'h0 |=> page_reg == $past(wdata_s);
  endproperty
  a_page_alias: assert property (p_page_alias) else $error("page write lost");

  property p_page_persist;
    @(posedge i_clk) disable iff (!i_resetn)
    !(wr_go && eff_addr[2:0] == 3'h0) |=> $stable(page_reg);
  endproperty
  a_page_persist: assert property (p_page_persist) else $error("page changed");

  property p_ded_addr;
    @(posedge i_clk) disable iff (!i_resetn)
    !muxed_s |-> eff_addr == {page_reg[2:0], addr_s[2:0]};
  endproperty
  a_ded_addr: assert property (p_ded_addr) else $error("dedicated address wrong");

  property p_linear;
    @(posedge i_clk) disable iff (!i_resetn)
    muxed_s && !page_reg[7] |-> eff_addr == lat_addr_reg;
  endproperty
  a_linear: assert property (p_linear) else $error("linear address wrong");

  property p_rw_hold;
    @(posedge i_clk) disable iff (!i_resetn)
    !(wr_go && eff_addr == prad_pkg::ADDR_INT_EN) |=> $stable(regs_reg[6]);
  endproperty
  a_rw_hold: assert property (p_rw_hold) else $error("control bits changed");

  property p_dyn_upd;
    @(posedge i_clk) disable iff (!i_resetn)
    i_dyn_wr.valid && i_dyn_wr.addr == prad_pkg::ADDR_INT_REQ
    |=> regs_reg[7] == $past(i_dyn_wr.data);
  endproperty
  a_dyn_upd: assert property (p_dyn_upd) else $error("engine update lost");

  property p_cmd_done;
    @(posedge i_clk) disable iff (!i_resetn)
    i_cmd_done |=> regs_reg[1] == prad_pkg::CMD_IDLE;
  endproperty
  a_cmd_done: assert property (p_cmd_done) else $error("command not idled");

  property p_ro_stable;
    @(posedge i_clk) disable iff (!i_resetn)
    wr_go && acc == prad_pkg::ACC_RO |=> $stable(regs_reg) && $stable(page_reg)
      || $past(i_dyn_wr.valid) || $past(i_cmd_done);
  endproperty
  a_ro_stable: assert property (p_ro_stable) else $error("read-only write took");

  property p_wo_read;
    @(posedge i_clk) disable iff (!i_resetn)
    rd_go && acc == prad_pkg::ACC_WO |=> o_rd_valid && o_rd_data == 8'h00;
  endproperty
  a_wo_read: assert property (p_wo_read) else $error("write-only read wrong");

  property p_rw_read;
    @(posedge i_clk) disable iff (!i_resetn)
    rd_go && acc == prad_pkg::ACC_RW |=> o_rd_data == $past(regs_reg[eff_addr]);
  endproperty
  a_rw_read: assert property (p_rw_read) else $error("read data wrong");

  // Engine writes only reach dynamic entries, so nothing else can disturb these
  property p_rw_write;
    @(posedge i_clk) disable iff (!i_resetn)
    wr_go && acc == prad_pkg::ACC_RW |=> regs_reg[$past(eff_addr)] == $past(wdata_s);
  endproperty
  a_rw_write: assert property (p_rw_write) else $error("control write lost");

  property p_wo_write;
    @(posedge i_clk) disable iff (!i_resetn)
    wr_go && acc == prad_pkg::ACC_WO |=> regs_reg[$past(eff_addr)] == $past(wdata_s);
  endproperty
  a_wo_write: assert property (p_wo_write) else $error("write-only write lost");

endmodule // prad_regbank

/* File: test/prad_cpu_model.sv */
`timescale 1ns/1ns
module prad_cpu_model (
  input wire logic i_clk,
  output logic o_ale,
  output logic o_wr_strobe,
  output logic o_rd_strobe,
  output logic [5:0] o_addr_lines,
  output logic [7:0] o_wdata
);
  // ==========================================================
  // Pin driver, all changes on the falling edge
  initial begin
    o_ale = 1'b0;
    o_wr_strobe = 1'b0;
    o_rd_strobe = 1'b0;
    o_addr_lines = 6'h00;
    o_wdata = 8'h00;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  // Caller picks the page before leaving it and writes zero to unused bits
  task automatic access(input logic muxed, input logic wr, input logic [5:0] a,
                        input logic [7:0] d);
    o_addr_lines = a;
    o_wdata = d;
    if (muxed) begin
      // All six lines in one latch phase
      o_ale = 1'b1;
      cyc(3);
      o_ale = 1'b0;
    end
    cyc(1);
    if (wr) o_wr_strobe = 1'b1;
    else o_rd_strobe = 1'b1;
    cyc(5);
    o_wr_strobe = 1'b0;
    o_rd_strobe = 1'b0;
    cyc(3);
    // Released lines must not keep looking valid
    o_addr_lines = ~o_addr_lines;
    o_wdata = ~o_wdata;
    // Let an edge pass so a following call does not overwrite the lines at once
    cyc(1);
  endtask
endmodule // prad_cpu_model

/* File: test/paged_register_address_decode_tb.sv */
`timescale 1ns/1ns
module paged_register_address_decode_tb;
  logic i_clk = 1'b0;
  logic i_resetn;
  logic i_bus_muxed;
  logic i_cmd_done;
  prad_pkg::prad_dyn_wr_t i_dyn_wr;
  prad_pkg::prad_status_t i_status;
  logic ale, wr, rd, rd_valid, cmd_start, pg_en;
  logic [5:0] addr;
  logic [7:0] wdata, rd_data, d, dv;
  logic [2:0] pg_num;
  logic [511:0] img;
  logic [8:0] e;
  logic [8:0] exp_q[$];
  logic [31:0] lfsr = 32'h889e;
  int err_total = 0;
  int comparisons = 0;
  int cmd_seen = 0;

  initial forever #5 i_clk = ~i_clk;

  prad_cpu_model cpu_u (.i_clk(i_clk), .o_ale(ale), .o_wr_strobe(wr), .o_rd_strobe(rd),
    .o_addr_lines(addr), .o_wdata(wdata));

  prad_regbank dut_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_bus_muxed(i_bus_muxed),
    .i_ale(ale), .i_wr_strobe(wr), .i_rd_strobe(rd), .i_addr_lines(addr), .i_wdata(wdata),
    .i_cmd_done(i_cmd_done), .i_dyn_wr(i_dyn_wr), .i_status(i_status), .o_rd_data(rd_data),
    .o_rd_valid(rd_valid), .o_cmd_start(cmd_start), .o_paging_mode_enable(pg_en),
    .o_page_number_field(pg_num), .o_reg_image(img));

  // ==========================================================
  // Helpers
  task automatic rnd(output logic [7:0] v);
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    v = lfsr[7:0];
  endtask

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [5:0] a, input logic [7:0] v);
    cpu_u.access(i_bus_muxed, 1'b1, a, v);
  endtask

  // chk low marks a location whose read value is not defined
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] v, input logic chk);
    exp_q.push_back({chk, v});
    cpu_u.access(i_bus_muxed, 1'b0, a, 8'h00);
  endtask

  task automatic engine(input logic [5:0] a, input logic [7:0] v);
    i_dyn_wr = {1'b1, a, v};
    @(negedge i_clk);
    i_dyn_wr = '0;
    @(negedge i_clk);
  endtask

  task automatic print_verdict();
    if (err_total == 0 && comparisons > 0 && exp_q.size() == 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ==========================================================
  // Result watcher, sampled mid-cycle where outputs are settled
  always @(negedge i_clk) begin
    if (cmd_start === 1'b1) cmd_seen++;
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        err_total++;
        $display("Error %0t: unexpected read data", $time);
      end else begin
        e = exp_q.pop_front();
        if (e[8]) cmp8(rd_data, e[7:0]);
      end
    end
  end

  initial begin
    repeat (20000) @(posedge i_clk);
    err_total++;
    print_verdict();
  end

  // ==========================================================
  // Main sequence
  initial begin
    i_resetn = 1'b0;
    i_bus_muxed = 1'b0;
    i_cmd_done = 1'b0;
    i_dyn_wr = '0;
    i_status = '0;
    repeat (10) @(negedge i_clk);
    i_resetn = 1'b1;
    @(negedge i_clk);
    cmp8({pg_en, 4'h0, pg_num}, 8'h80);
    rd_chk(6'h00, 8'h80, 1'b1);
    // Offset 6 of pages 2..6 is plain storage in every one of them
    for (int p = 2; p < 7; p++) begin
      wr_reg(6'h00, 8'h80 | 8'(p));
      cmp8({5'h00, pg_num}, 8'(p));
      rnd(d);
      wr_reg(6'h06, d);
      cmp8(img[8 * (8 * p + 6) +: 8], d);
      rd_chk(6'h00, 8'h80 | 8'(p), 1'b1);
      rd_chk(6'h06, d, 1'b1);
    end
    // Muxed bus, paged: upper lines ignored, page 6 used
    i_bus_muxed = 1'b1;
    repeat (4) @(negedge i_clk);
    rnd(d);
    wr_reg(6'h1d, d);
    cmp8(img[8 * 6'h35 +: 8], d);
    rd_chk(6'h05, d, 1'b1);
    wr_reg(6'h38, 8'h00);
    cmp8({7'h00, pg_en}, 8'h00);
    rd_chk(6'h35, d, 1'b1);
    rnd(d);
    wr_reg(6'h3a, d);
    rd_chk(6'h3a, d, 1'b1);
    // Read-only flags ignore writes
    rnd(i_status.err_flag);
    rnd(i_status.pri_status);
    wr_reg(6'h0a, ~i_status.err_flag);
    cmp8(img[8 * 6'h0a +: 8], 8'h00);
    rd_chk(6'h0a, i_status.err_flag, 1'b1);
    rd_chk(6'h03, i_status.pri_status, 1'b1);
    // Command register: written, then cleared by completion
    wr_reg(6'h01, 8'h0c);
    rd_chk(6'h01, 8'h0c, 1'b1);
    i_cmd_done = 1'b1;
    @(negedge i_clk);
    i_cmd_done = 1'b0;
    @(negedge i_clk);
    rd_chk(6'h01, 8'h00, 1'b1);
    rnd(dv);
    engine(6'h09, dv);
    rd_chk(6'h09, dv, 1'b1);
    engine(6'h07, ~dv);
    rd_chk(6'h07, ~dv, 1'b1);
    engine(6'h3a, ~d);
    rd_chk(6'h3a, d, 1'b1);
    // Write-only: write lands, read value is not defined
    rnd(d);
    wr_reg(6'h3d, d);
    cmp8(img[8 * 6'h3d +: 8], d);
    rd_chk(6'h3d, 8'h00, 1'b0);
    cmp8(8'(cmd_seen), 8'h01);
    print_verdict();
  end
endmodule // paged_register_address_decode_tb
